//--- common/flash_host_pkg.sv
package flash_host_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_CFG     = 8'h04;
  localparam logic [7:0] OFS_ADDR    = 8'h08;
  localparam logic [7:0] OFS_WDATA   = 8'h0c;
  localparam logic [7:0] OFS_RDATA   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_UADDR1  = 8'h18;
  localparam logic [7:0] OFS_UADDR2  = 8'h1c;
  localparam logic [7:0] OFS_UDATA   = 8'h20;
  localparam logic [7:0] OFS_CODES   = 8'h24;

  // operation codes written to the command register, bits [2:0]
  localparam logic [2:0] OP_WRITE    = 3'h1;
  localparam logic [2:0] OP_READ     = 3'h2;
  localparam logic [2:0] OP_ID_ENTER = 3'h3;
  localparam logic [2:0] OP_RESET    = 3'h4;
  localparam logic [2:0] OP_HW_RESET = 3'h5;

  // field positions
  localparam int CFG_HV_A9    = 0;
  localparam int CFG_HV_RESET = 1;
  localparam int ST_BUSY      = 0;
  localparam int ST_ID_MODE   = 1;
  localparam int ST_PROTECTED = 2;
  localparam int ST_RST_LOW   = 3;
  localparam int ID_SEL_LSB   = 0;
  localparam int ADDR_SIX     = 6;

  // low address byte of the sector protection query
  localparam logic [7:0] ID_SEL_PROTECT = 8'h02;

  // reset values
  localparam logic [ADDR_W-1:0] UADDR_RST = 18'h00000;
  localparam logic [15:0]       UDATA_RST = 16'h0000;
  localparam logic [15:0]       CODES_RST = 16'h0000;

  // timing
  localparam int T_CLK_NS = 100;
  localparam int T_WP_NS  = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_RP_NS  = 500;
  localparam int T_RH_NS  = 50;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'(ceil_cyc(T_WP_NS));
  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'(ceil_cyc(T_ACC_NS));
  localparam logic [CNT_W-1:0] RP_CYC  = CNT_W'(ceil_cyc(T_RP_NS));
  localparam logic [CNT_W-1:0] RH_CYC  = CNT_W'(ceil_cyc(T_RH_NS));

endpackage : flash_host_pkg

//--- dv/flash_dev_model.sv
module flash_dev_model #(
  parameter logic [17:0] UA1    = 18'h01234,
  parameter logic [17:0] UA2    = 18'h00567,
  parameter logic [7:0]  UD1    = 8'hc3,
  parameter logic [7:0]  UD2    = 8'h3c,
  parameter logic [7:0]  IDC    = 8'h9a,
  parameter logic [7:0]  RSC    = 8'he1,
  parameter logic [3:0]  PROT   = 4'h0,
  // identity codes below are arbitrary
  parameter logic [7:0]  MAKER  = 8'h51,
  parameter logic [7:0]  DEVICE = 8'h62,
  parameter logic [7:0]  CONT   = 8'h73
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        hv_a9,
  input  wire logic [17:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] lat_a;
  logic [1:0]  step;
  logic        id_mode;
  bit          pu_block;
  logic [7:0]  last;
  realtime     t_fall;
  wire drive  = !ce_n && !oe_n && we_n && reset_n;
  wire id_hit = (id_mode && addr[7:2] == 6'h00) || (hv_a9 && !addr[6]);
  wire [7:0] code = addr[1:0] == 2'd0 ? MAKER : addr[1:0] == 2'd1 ? DEVICE :
                    addr[1:0] == 2'd2 ? {7'h00, PROT[addr[17:16]]} : CONT;
  wire [7:0] rd_val = id_hit ? code : addr[7:0] ^ addr[15:8] ^ 8'h3c;
  // a released bus shows the inverse so stale data never matches
  assign dq = drive ? rd_val : ~last;
  always @(rd_val or drive) if (drive) last = rd_val;
  initial begin
    step = 2'd0;
    id_mode = 1'b0;
    last = 8'h00;
    t_fall = 0.0;
    pu_block = 1'b0;
    // strobes already low as power comes up: drop the first rise
    #1 pu_block = (ce_n === 1'b0) && (we_n === 1'b0) && (oe_n === 1'b1);
  end
  task automatic take(input logic [17:0] a, input logic [7:0] d);
    if (d == RSC) begin
      step = 2'd0;
      id_mode = 1'b0;
    end else if (id_mode) begin
      step = 2'd0;
    end else if (step == 2'd0 && a == UA1 && d == UD1) step = 2'd1;
    else if (step == 2'd1 && a == UA2 && d == UD2) step = 2'd2;
    else if (step == 2'd2 && a == UA1 && d == IDC) begin
      step = 2'd0;
      id_mode = 1'b1;
    end else step = 2'd0;
  endtask : take
  always @(negedge ce_n or negedge we_n) begin
    if (!ce_n && !we_n && oe_n) begin
      lat_a = addr;
      t_fall = $realtime;
    end
  end
  always @(posedge ce_n or posedge we_n) begin
    if (pu_block) pu_block = 1'b0;
    else if (!(ce_n && we_n) && oe_n && reset_n
             && $realtime - t_fall >= 5.0)
      take(lat_a, dq_in);
  end
  always @(negedge reset_n) begin
    step = 2'd0;
    id_mode = 1'b0;
  end
endmodule : flash_dev_model

//--- dv/flash_host_ctrl_assertions.sv
module flash_host_ctrl_assertions (
  input wire logic                              hclk,
  input wire logic                              hresetn,
  input wire logic                              hreadyout,
  input wire logic                              hresp,
  input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic                              flash_dq_oe,
  input wire logic                              flash_ce_n,
  input wire logic                              flash_oe_n,
  input wire logic                              flash_we_n,
  input wire logic                              flash_reset_n,
  input wire logic                              hv_a9_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // write strobe ends first, then the chip select
  sequence wr_tail;
    flash_we_n ##1 flash_ce_n;
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_strobe_excl: assert property (flash_oe_n || flash_we_n)
    else $error("output gate and write strobe low together");
  chk_we_needs_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe low without select or data drive");
  chk_we_after_ce: assert property ($fell(flash_we_n) |-> $past(!flash_ce_n))
    else $error("write strobe fell before chip select");
  chk_we_pulse: assert property ($fell(flash_we_n) |=> wr_tail)
    else $error("write cycle does not close in order");
  chk_addr_hold: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved while selected");
  chk_data_hold: assert property ($rose(flash_we_n) |-> $stable(flash_dq_out) && flash_dq_oe)
    else $error("write data not held at strobe rise");
  chk_reset_quiet: assert property (!flash_reset_n |-> flash_ce_n && flash_oe_n && flash_we_n)
    else $error("strobe active during reset pulse");
  chk_reset_width: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*5] ##1 flash_reset_n)
    else $error("reset pulse width wrong");
  chk_hv_a6_low: assert property (hv_a9_en && !flash_ce_n |-> !flash_addr[6])
    else $error("address bit six high under elevated bit nine");
endmodule : flash_host_ctrl_assertions

//--- dv/test_flash_host_ctrl.sv
module test_flash_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] UA1 = 18'h01234;
  localparam logic [17:0] UA2 = 18'h00567;
  localparam logic [7:0]  UD1 = 8'hc3;
  localparam logic [7:0]  UD2 = 8'h3c;
  localparam logic [7:0]  IDC = 8'h9a;
  localparam logic [7:0]  RSC = 8'he1;
  localparam logic [3:0]  PROT = 4'h2;
  localparam logic [7:0]  MAKER = 8'h51;
  localparam logic [7:0]  DEVICE = 8'h62;
  localparam logic [7:0]  CONT = 8'h73;
  logic        hclk, hresetn, hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, r;
  logic [17:0] a;
  wire         hreadyout, hresp, dq_oe, ce_n, oe_n, we_n, rst_n, hv_a9, hv_rst;
  wire  [31:0] hrdata;
  wire  [17:0] faddr;
  wire  [7:0]  dq_out, dq_m;
  wire  [7:0]  dq_bus = dq_oe ? dq_out : dq_m;
  int          n_mismatch, n_checks, cyc, seed;
  bit          idm;

  flash_host_ctrl flash_host_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flash_addr(faddr), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_bus), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n),
    .hv_a9_en(hv_a9), .hv_reset_en(hv_rst));
  flash_dev_model #(.UA1(UA1), .UA2(UA2), .UD1(UD1), .UD2(UD2), .IDC(IDC),
    .RSC(RSC), .PROT(PROT), .MAKER(MAKER), .DEVICE(DEVICE), .CONT(CONT))
    flash_dev_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(rst_n), .hv_a9(hv_a9), .addr(faddr), .dq_in(dq_bus), .dq(dq_m));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, ad};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, ad, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    ahb(1'b0, ad, 32'h0, q);
  endtask : rd
  task automatic cmd(input logic [2:0] op);
    logic [31:0] s;
    int k;
    wr(flash_host_pkg::OFS_CMD, {29'h0, op});
    k = 0;
    do begin
      rd(flash_host_pkg::OFS_STATUS, s);
      k++;
    end while (s[0] !== 1'b0 && k < 50);
    check({31'h0, s[0]}, 32'h0, "busy stuck");
  endtask : cmd
  task automatic fwr(input logic [17:0] fa, input logic [7:0] d);
    wr(flash_host_pkg::OFS_ADDR, {14'h0, fa});
    wr(flash_host_pkg::OFS_WDATA, {24'h0, d});
    cmd(flash_host_pkg::OP_WRITE);
  endtask : fwr
  // expected byte from the device side, independent of the design
  function automatic logic [7:0] exp_rd(input logic [17:0] fa, input bit hv);
    if ((idm && fa[7:2] == 6'h00) || hv)
      case (fa[1:0])
        2'd0: return MAKER;
        2'd1: return DEVICE;
        2'd2: return {7'h00, PROT[fa[17:16]]};
        default: return CONT;
      endcase
    return fa[7:0] ^ fa[15:8] ^ 8'h3c;
  endfunction : exp_rd
  task automatic frd(input logic [17:0] fa, input bit hv);
    logic [31:0] q;
    wr(flash_host_pkg::OFS_ADDR, {14'h0, fa});
    cmd(flash_host_pkg::OP_READ);
    rd(flash_host_pkg::OFS_RDATA, q);
    check(q, {24'h0, exp_rd(fa, hv)}, "flash read");
  endtask : frd

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    hresetn = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cyc = 0;
    seed = 32'ha28f;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(flash_host_pkg::OFS_STATUS, r);
    check(r, 32'h0, "status after reset");
    rd(8'h3c, r);
    check(r, 32'h0, "unmapped read");
    rd(flash_host_pkg::OFS_CODES, r);
    check(r, 32'h0, "codes after reset");
    check({31'h0, ce_n}, 32'h1, "select idle");
    a = 18'($random(seed));
    frd(a, 1'b0);
    wr(flash_host_pkg::OFS_UADDR1, {14'h0, UA1});
    wr(flash_host_pkg::OFS_UADDR2, {14'h0, UA2});
    wr(flash_host_pkg::OFS_UDATA, {16'h0, UD2, UD1});
    wr(flash_host_pkg::OFS_CODES, {16'h0, RSC, IDC});
    rd(flash_host_pkg::OFS_CODES, r);
    check(r, {16'h0, RSC, IDC}, "codes readback");
    // without the abort these three writes would complete id entry
    fwr(UA1, UD1);
    cmd(flash_host_pkg::OP_RESET);
    fwr(UA2, UD2);
    fwr(UA1, IDC);
    frd(UA1 & 18'h3ff00, 1'b0);
    fwr(UA1, UD1);
    fwr(UA1, UD1);
    fwr(UA1, IDC);
    frd(UA1 & 18'h3ff00, 1'b0);
    cmd(flash_host_pkg::OP_ID_ENTER);
    idm = 1'b1;
    rd(flash_host_pkg::OFS_STATUS, r);
    check(r, 32'h2, "id mode flag");
    for (int i = 0; i < 16; i++) begin
      a = 18'($random(seed));
      a[7:0] = {6'h0, 2'(i)};
      a[17:16] = 2'(i >> 2);
      frd(a, 1'b0);
      rd(flash_host_pkg::OFS_STATUS, r);
      if (i % 4 == 2) check(r, {29'h0, PROT[i>>2], 2'b10}, "protect flag");
    end
    fwr(a, UD1);
    frd(18'h0, 1'b0);
    cmd(flash_host_pkg::OP_RESET);
    idm = 1'b0;
    rd(flash_host_pkg::OFS_STATUS, r);
    check(r, 32'h0, "id mode left");
    frd(18'h0, 1'b0);
    wr(flash_host_pkg::OFS_CFG, 32'h1);
    // the register lands at the edge wr returns on
    @(posedge hclk);
    check({31'h0, hv_a9}, 32'h1, "elevated bit nine");
    for (int i = 0; i < 4; i++) begin
      a = 18'($random(seed));
      a[1:0] = 2'(i);
      a[6] = 1'b1;
      frd(a, 1'b1);
    end
    wr(flash_host_pkg::OFS_CFG, 32'h2);
    @(posedge hclk);
    check({30'h0, hv_rst, hv_a9}, 32'h2, "elevated reset pin");
    wr(flash_host_pkg::OFS_CFG, 32'h0);
    cmd(flash_host_pkg::OP_ID_ENTER);
    cmd(flash_host_pkg::OP_HW_RESET);
    idm = 1'b0;
    rd(flash_host_pkg::OFS_STATUS, r);
    check(r, 32'h0, "status after pulse");
    frd(18'h00100, 1'b0);
    stop_test();
  end
endmodule : test_flash_host_ctrl

bind flash_host_ctrl flash_host_ctrl_assertions flash_host_ctrl_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_reset_n(flash_reset_n), .hv_a9_en(hv_a9_en));

//--- logic/flash_bus_cycle.sv
// one strobe cycle on the flash pins, read or write
module flash_bus_cycle (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              start,
  input  wire logic                              is_write,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] wdata,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output logic                                   ce_n,
  output logic                                   oe_n,
  output logic                                   we_n,
  output logic      [flash_host_pkg::ADDR_W-1:0] addr_out,
  output logic      [flash_host_pkg::DATA_W-1:0] dq_out,
  output logic                                   dq_oe,
  output logic      [flash_host_pkg::DATA_W-1:0] rdata,
  output logic                                   done
);

  typedef enum logic [2:0] {
    C_IDLE, C_SETUP, C_STROBE, C_RELEASE, C_END
  } cyc_state_t;

  cyc_state_t                        state_reg;
  logic [flash_host_pkg::CNT_W-1:0] cnt_reg;
  logic                              wr_reg;

  wire cnt_zero = (cnt_reg == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= C_IDLE;
      cnt_reg   <= '0;
      wr_reg    <= 1'b0;
      ce_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
      addr_out  <= '0;
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      rdata     <= '0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (start) begin
            addr_out  <= addr;
            dq_out    <= wdata;
            wr_reg    <= is_write;
            ce_n      <= 1'b0;
            state_reg <= C_SETUP;
          end
        end
        C_SETUP: begin
          // ce falls first so the address is taken on the we fall
          if (wr_reg) begin
            we_n    <= 1'b0;
            dq_oe   <= 1'b1;
            cnt_reg <= flash_host_pkg::WP_CYC - 1'b1;
          end else begin
            oe_n    <= 1'b0;
            cnt_reg <= flash_host_pkg::ACC_CYC - 1'b1;
          end
          state_reg <= C_STROBE;
        end
        C_STROBE: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            if (wr_reg) begin
              we_n <= 1'b1;
            end else begin
              rdata <= dq_in;
              oe_n  <= 1'b1;
            end
            state_reg <= C_RELEASE;
          end
        end
        C_RELEASE: begin
          // data held past the we rise for hold time
          ce_n      <= 1'b1;
          state_reg <= C_END;
        end
        C_END: begin
          dq_oe     <= 1'b0;
          done      <= 1'b1;
          state_reg <= C_IDLE;
        end
        default: state_reg <= C_IDLE;
      endcase
    end
  end

endmodule : flash_bus_cycle

//--- logic/flash_host_ctrl.sv
module flash_host_ctrl (
  input  wire logic                              hclk,
  input  wire logic                              hresetn,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic                                   hreadyout,
  output logic                                   hresp,
  output logic      [31:0]                       hrdata,
  output logic      [flash_host_pkg::ADDR_W-1:0] flash_addr,
  output logic      [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  output logic                                   flash_dq_oe,
  input  wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
  output logic                                   flash_ce_n,
  output logic                                   flash_oe_n,
  output logic                                   flash_we_n,
  output logic                                   flash_reset_n,
  output logic                                   hv_a9_en,
  output logic                                   hv_reset_en
);

  localparam int AW = flash_host_pkg::ADDR_W;
  localparam int DW = flash_host_pkg::DATA_W;

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_WAIT, M_RST_LOW, M_RST_REC
  } main_state_t;

  // bus slave
  logic        wr_pend_reg;
  logic [7:0]  wr_ofs_reg;
  logic [31:0] hrdata_reg;

  // software registers
  logic [1:0]    cfg_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic [DW-1:0] rdata_reg;
  logic [AW-1:0] uaddr1_reg;
  logic [AW-1:0] uaddr2_reg;
  logic [15:0]   udata_reg;
  logic [15:0]   codes_reg;

  // sequencer
  main_state_t                      state_reg;
  logic [2:0]                       op_reg;
  logic [1:0]                       step_reg;
  logic [flash_host_pkg::CNT_W-1:0] cnt_reg;
  logic                             id_mode_reg;
  logic                             protected_reg;
  logic                             reset_n_reg;

  logic                             cyc_done;
  logic [DW-1:0]                    cyc_rdata;

  wire addr_phase = hsel & htrans[1] & hready;
  wire busy       = (state_reg != M_IDLE);
  wire wr_cmd     = wr_pend_reg & (wr_ofs_reg == flash_host_pkg::OFS_CMD);
  wire [2:0] new_op = hwdata[2:0];
  wire op_valid   = (new_op == flash_host_pkg::OP_WRITE)
                  | (new_op == flash_host_pkg::OP_READ)
                  | (new_op == flash_host_pkg::OP_ID_ENTER)
                  | (new_op == flash_host_pkg::OP_RESET)
                  | (new_op == flash_host_pkg::OP_HW_RESET);
  // a command written while busy is dropped, software polls busy first
  wire launch     = wr_cmd & ~busy & op_valid;
  wire launch_hw  = launch & (new_op == flash_host_pkg::OP_HW_RESET);

  // programmer method needs address bit six low under high voltage
  wire [AW-1:0] addr_eff = cfg_reg[flash_host_pkg::CFG_HV_A9]
    ? {addr_reg[AW-1:7], 1'b0, addr_reg[5:0]}
    : addr_reg;

  // unlock pair then id command; codes are software loaded
  wire is_id  = (op_reg == flash_host_pkg::OP_ID_ENTER);
  wire is_rst = (op_reg == flash_host_pkg::OP_RESET);
  wire is_rd  = (op_reg == flash_host_pkg::OP_READ);
  wire [AW-1:0] cyc_addr =
      !is_id           ? addr_eff   :
      (step_reg == 2'd1) ? uaddr2_reg : uaddr1_reg;
  wire [DW-1:0] cyc_wdata =
      is_rst             ? codes_reg[15:8] :
      !is_id             ? wdata_reg       :
      (step_reg == 2'd0) ? udata_reg[7:0]  :
      (step_reg == 2'd1) ? udata_reg[15:8] : codes_reg[7:0];
  wire [1:0] last_step = is_id ? 2'd2 : 2'd0;
  wire       seq_end   = cyc_done & (step_reg == last_step);

  // protection query reads return the flag in bit zero
  wire prot_query = id_mode_reg
                  & (addr_reg[7:0] == flash_host_pkg::ID_SEL_PROTECT);

  wire [31:0] status_word = {28'h0000000, ~reset_n_reg, protected_reg,
                             id_mode_reg, busy};

  wire [7:0] rd_ofs = haddr[7:0];
  wire [31:0] rd_mux =
    (rd_ofs == flash_host_pkg::OFS_CFG)    ? {30'h00000000, cfg_reg} :
    (rd_ofs == flash_host_pkg::OFS_ADDR)   ? {14'h0000, addr_reg}    :
    (rd_ofs == flash_host_pkg::OFS_WDATA)  ? {24'h000000, wdata_reg} :
    (rd_ofs == flash_host_pkg::OFS_RDATA)  ? {24'h000000, rdata_reg} :
    (rd_ofs == flash_host_pkg::OFS_STATUS) ? status_word             :
    (rd_ofs == flash_host_pkg::OFS_UADDR1) ? {14'h0000, uaddr1_reg}  :
    (rd_ofs == flash_host_pkg::OFS_UADDR2) ? {14'h0000, uaddr2_reg}  :
    (rd_ofs == flash_host_pkg::OFS_UDATA)  ? {16'h0000, udata_reg}   :
    (rd_ofs == flash_host_pkg::OFS_CODES)  ? {16'h0000, codes_reg}   :
                                             32'h00000000;

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_reg;
  assign flash_reset_n = reset_n_reg;
  assign hv_a9_en      = cfg_reg[flash_host_pkg::CFG_HV_A9];
  // high voltage on reset lifts protection only while held
  assign hv_reset_en   = cfg_reg[flash_host_pkg::CFG_HV_RESET];

  flash_bus_cycle u_cycle (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (state_reg == M_START),
    .is_write (~is_rd),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .dq_in    (flash_dq_in),
    .ce_n     (flash_ce_n),
    .oe_n     (flash_oe_n),
    .we_n     (flash_we_n),
    .addr_out (flash_addr),
    .dq_out   (flash_dq_out),
    .dq_oe    (flash_dq_oe),
    .rdata    (cyc_rdata),
    .done     (cyc_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_ofs_reg  <= haddr[7:0];
      if (addr_phase & ~hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg    <= 2'b00;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      uaddr1_reg <= flash_host_pkg::UADDR_RST;
      uaddr2_reg <= flash_host_pkg::UADDR_RST;
      udata_reg  <= flash_host_pkg::UDATA_RST;
      codes_reg  <= flash_host_pkg::CODES_RST;
    end else if (wr_pend_reg) begin
      case (wr_ofs_reg)
        flash_host_pkg::OFS_CFG:    cfg_reg    <= hwdata[1:0];
        flash_host_pkg::OFS_ADDR:   addr_reg   <= hwdata[AW-1:0];
        flash_host_pkg::OFS_WDATA:  wdata_reg  <= hwdata[DW-1:0];
        flash_host_pkg::OFS_UADDR1: uaddr1_reg <= hwdata[AW-1:0];
        flash_host_pkg::OFS_UADDR2: uaddr2_reg <= hwdata[AW-1:0];
        flash_host_pkg::OFS_UDATA:  udata_reg  <= hwdata[15:0];
        flash_host_pkg::OFS_CODES:  codes_reg  <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= M_IDLE;
      op_reg    <= 3'h0;
      step_reg  <= 2'd0;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        M_IDLE: begin
          if (launch) begin
            op_reg    <= new_op;
            step_reg  <= 2'd0;
            cnt_reg   <= flash_host_pkg::RP_CYC - 1'b1;
            state_reg <= launch_hw ? M_RST_LOW : M_START;
          end
        end
        M_START: state_reg <= M_WAIT;
        M_WAIT: begin
          if (seq_end) begin
            state_reg <= M_IDLE;
          end else if (cyc_done) begin
            step_reg  <= step_reg + 2'd1;
            state_reg <= M_START;
          end
        end
        M_RST_LOW: begin
          // no strobe issued while reset is low
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            cnt_reg   <= flash_host_pkg::RH_CYC - 1'b1;
            state_reg <= M_RST_REC;
          end
        end
        M_RST_REC: begin
          if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            state_reg <= M_IDLE;
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_n_reg <= 1'b1;
    end else begin
      // the last count cycle already releases the pin, so it stays low
      // for exactly the reset width and recovery starts on time
      reset_n_reg <= ~((state_reg == M_IDLE) ? launch_hw
                       : ((state_reg == M_RST_LOW) && (cnt_reg != '0)));
    end
  end

  // host copy of the device mode: array read after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_mode_reg   <= 1'b0;
      protected_reg <= 1'b0;
      rdata_reg     <= '0;
    end else begin
      if (state_reg == M_RST_REC) begin
        id_mode_reg <= 1'b0;
      end else if (seq_end & is_id) begin
        id_mode_reg <= 1'b1;
      end else if (seq_end & is_rst) begin
        id_mode_reg <= 1'b0;
      end
      if (cyc_done & is_rd) begin
        rdata_reg <= cyc_rdata;
        if (prot_query) begin
          protected_reg <= cyc_rdata[0];
        end
      end
    end
  end

endmodule : flash_host_ctrl
